// ===== rtl/lock_det_pkg.sv
package lock_det_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_ACQ_CTRL  = 4'h8;  // acquisition_control_reg
  localparam logic [3:0] ADDR_LOCK_CTRL = 4'h9;  // lock_control_reg
  localparam logic [3:0] ADDR_STATUS    = 4'h4;  // Live and sticky state
  localparam logic [3:0] ADDR_IRQ_STAT  = 4'hA;
  localparam logic [3:0] ADDR_IRQ_CLR   = 4'hB;
  localparam logic [3:0] ADDR_IRQ_EN    = 4'hC;

  // Field positions
  localparam int ACQ_REF_SEL   = 0;
  localparam int ACQ_DIV_LO    = 2;
  localparam int ACQ_RANGE_LO  = 6;
  localparam int LCK_STICKY_CLR = 6;
  localparam int LCK_PIN_MODE   = 7;
  localparam int ST_LIVE        = 3;
  localparam int ST_STICKY      = 4;

  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Interrupt bits: loss event and lock event
  localparam int IRQ_LOSS = 0;
  localparam int IRQ_LOCK = 1;
  localparam int IRQ_W    = 2;

  // ---------------------------------------------------------------
  // Thresholds in ppm
  // ---------------------------------------------------------------
  localparam int PPM_SET   = 1000;
  localparam int PPM_CLEAR = 250;
  localparam int PPM_SCALE = 1000000;

  typedef enum logic [1:0] {
    MODE_DATA,
    MODE_REF
  } ref_mode_t;

  typedef enum logic [1:0] {
    ST_ACQUIRE,
    ST_TRACK
  } lock_state_t;

  // Result of one gate interval
  typedef struct packed {
    logic        valid;
    logic [23:0] vco_cnt;
    logic [23:0] tgt_cnt;
  } measure_t;

endpackage : lock_det_pkg

// ===== rtl/edge_counter.sv
`timescale 1ns/10ps
// Synchronises a toggle input and counts its rising edges
module edge_counter
  import lock_det_pkg::*;
#(
  parameter int W = 24
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_sig,
  input  wire logic         i_clear,
  output logic [W-1:0]      o_count
);

  logic sync1;
  logic sync2;
  logic sync3;

  // -------------------------------------------------------------
  // Two-stage synchroniser, third stage for edge detection
  // -------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= i_sig;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Clear restarts the gate; an edge on that cycle is counted
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_count <= '0;
    end else if (i_clear) begin
      o_count <= {{(W-1){1'b0}}, (sync2 & ~sync3)};
    end else if (sync2 & ~sync3) begin
      o_count <= o_count + 1'b1;
    end
  end

endmodule : edge_counter

// ===== rtl/cdr_lock_detector.sv
`timescale 1ns/10ps
module cdr_lock_detector
  import lock_det_pkg::*;
#(
  parameter int CNT_W     = 24,
  parameter int GATE_CYC  = 1000000  // Gate interval in clock cycles
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_vco_div,    // Divided oscillator
  input  wire logic         i_data_edge,  // Divided data transitions
  input  wire logic         i_aid_reference_clock,
  input  wire logic [3:0]   i_addr,
  input  wire logic [7:0]   i_wdata,
  input  wire logic         i_wr,
  input  wire logic         i_rd,
  output logic [7:0]        o_rdata,
  output logic              o_loss_of_lock_pin,
  output logic              o_frequency_acquisition_loop,
  output logic              o_phase_loop_en,
  output logic              o_ref_sel,
  output logic [1:0]        o_ref_range,
  output logic [3:0]        o_ref_div,
  output logic              o_irq
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0]        acquisition_control_reg;
  logic [7:0]        lock_control_reg;
  logic              loss_of_lock_flag;
  logic              sticky_lock_loss;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_en;
  lock_state_t       state;
  ref_mode_t         mode;
  logic [31:0]       gate_cnt;
  logic              gate_end;
  logic [CNT_W-1:0]  vco_cnt;
  logic [CNT_W-1:0]  data_cnt;
  logic [CNT_W-1:0]  ref_cnt;
  measure_t          meas;
  logic              too_far;
  logic              close_in;
  logic              loss_evt;
  logic              lock_evt;
  logic              sticky_clr_prev;
  logic [CNT_W+20:0] diff_ppm;
  logic [CNT_W+20:0] lim_set;
  logic [CNT_W+20:0] lim_clr;

  // Mode follows the reference select bit
  assign mode = acquisition_control_reg[ACQ_REF_SEL] ? MODE_REF
                                                      : MODE_DATA;

  // ---------------------------------------------------------------
  // Frequency counters
  // ---------------------------------------------------------------
  edge_counter #(.W(CNT_W)) u_vco (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_sig   (i_vco_div),
    .i_clear (gate_end),
    .o_count (vco_cnt)
  );

  edge_counter #(.W(CNT_W)) u_data (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_sig   (i_data_edge),
    .i_clear (gate_end),
    .o_count (data_cnt)
  );

  edge_counter #(.W(CNT_W)) u_ref (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_sig   (i_aid_reference_clock),
    .i_clear (gate_end),
    .o_count (ref_cnt)
  );

  // Fixed gate interval; counts restart when it ends
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      gate_cnt <= '0;
      gate_end <= 1'b0;
    end else if (gate_cnt == 32'(GATE_CYC - 1)) begin
      gate_cnt <= '0;
      gate_end <= 1'b1;
    end else begin
      gate_cnt <= gate_cnt + 32'h0000_0001;
      gate_end <= 1'b0;
    end
  end

  // Latch the counts of the finished gate; target depends on mode.
  // Reference count is taken as already scaled by the external
  // divider chain set from range and divide fields.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meas <= '0;
    end else begin
      meas.valid <= gate_end;
      if (gate_end) begin
        meas.vco_cnt <= vco_cnt;
        meas.tgt_cnt <= (mode == MODE_REF) ? ref_cnt
                                           : data_cnt;
      end
    end
  end

  // ---------------------------------------------------------------
  // ppm comparison: |a-b| * 1e6 against threshold * target
  // ---------------------------------------------------------------
  always_comb begin
    diff_ppm = (meas.vco_cnt > meas.tgt_cnt)
      ? (CNT_W+21)'(meas.vco_cnt - meas.tgt_cnt) * (CNT_W+21)'(PPM_SCALE)
      : (CNT_W+21)'(meas.tgt_cnt - meas.vco_cnt) * (CNT_W+21)'(PPM_SCALE);
    lim_set  = (CNT_W+21)'(meas.tgt_cnt) * (CNT_W+21)'(PPM_SET);
    lim_clr  = (CNT_W+21)'(meas.tgt_cnt) * (CNT_W+21)'(PPM_CLEAR);
    too_far  = diff_ppm > lim_set;
    close_in = (diff_ppm <= lim_clr) && (meas.tgt_cnt != '0);
  end

  // ---------------------------------------------------------------
  // Hysteretic flag and loop hand-over
  // ---------------------------------------------------------------
  assign loss_evt = meas.valid && (state == ST_TRACK) && too_far;
  assign lock_evt = meas.valid && (state == ST_ACQUIRE) && close_in;

  // Flag starts set: nothing is locked out of reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state             <= ST_ACQUIRE;
      loss_of_lock_flag <= 1'b1;
    end else if (loss_evt) begin
      state             <= ST_ACQUIRE;
      loss_of_lock_flag <= 1'b1;
    end else if (lock_evt) begin
      state             <= ST_TRACK;
      loss_of_lock_flag <= 1'b0;
    end // between thresholds nothing changes
  end

  // Loop enables are the flag and its inverse
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_frequency_acquisition_loop <= 1'b1;
      o_phase_loop_en              <= 1'b0;
    end else begin
      o_frequency_acquisition_loop <= ~lock_evt &
        (loss_evt | loss_of_lock_flag);
      o_phase_loop_en <= ~loss_evt &
        (lock_evt | ~loss_of_lock_flag);
    end
  end

  // ---------------------------------------------------------------
  // Sticky loss bit: set beats the clear on a falling clear bit
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sticky_clr_prev <= 1'b0;
    end else begin
      sticky_clr_prev <= lock_control_reg[LCK_STICKY_CLR];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sticky_lock_loss <= 1'b0;
    end else if (loss_evt) begin
      sticky_lock_loss <= 1'b1;
    end else if (sticky_clr_prev &&
                 !lock_control_reg[LCK_STICKY_CLR]) begin
      sticky_lock_loss <= 1'b0;
    end
  end

  // Pin shows sticky or live flag, one cycle behind
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_loss_of_lock_pin <= 1'b1;
    end else begin
      o_loss_of_lock_pin <= lock_control_reg[LCK_PIN_MODE]
        ? sticky_lock_loss : loss_of_lock_flag;
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      acquisition_control_reg <= CTRL_RESET;
      lock_control_reg        <= CTRL_RESET;
      irq_en                  <= '0;
    end else if (i_wr) begin
      if (i_addr == ADDR_ACQ_CTRL) begin
        acquisition_control_reg <= i_wdata;
      end
      if (i_addr == ADDR_LOCK_CTRL) begin
        lock_control_reg <= i_wdata;
      end
      if (i_addr == ADDR_IRQ_EN) begin
        irq_en <= i_wdata[IRQ_W-1:0];
      end
    end
  end

  // Mode fields go out to the analog dividers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ref_sel   <= 1'b0;
      o_ref_range <= '0;
      o_ref_div   <= '0;
    end else begin
      o_ref_sel   <= acquisition_control_reg[ACQ_REF_SEL];
      o_ref_range <= acquisition_control_reg[ACQ_RANGE_LO +: 2];
      o_ref_div   <= acquisition_control_reg[ACQ_DIV_LO +: 4];
    end
  end

  // Interrupt status: new events win over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_stat <= '0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if ((i == IRQ_LOSS && loss_evt) || (i == IRQ_LOCK && lock_evt)) begin
          irq_stat[i] <= 1'b1;
        end else if (i_wr && i_addr == ADDR_IRQ_CLR && i_wdata[i]) begin
          irq_stat[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat & irq_en);
    end
  end

  // Read data valid in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        ADDR_STATUS: begin
          o_rdata <= '0;
          o_rdata[ST_LIVE]   <= loss_of_lock_flag;
          o_rdata[ST_STICKY] <= sticky_lock_loss;
        end
        ADDR_ACQ_CTRL:  o_rdata <= acquisition_control_reg;
        ADDR_LOCK_CTRL: o_rdata <= lock_control_reg;
        ADDR_IRQ_STAT:  o_rdata <= {{(8-IRQ_W){1'b0}}, irq_stat};
        ADDR_IRQ_EN:    o_rdata <= {{(8-IRQ_W){1'b0}}, irq_en};
        default:        o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_loss;
    meas.valid && state == ST_TRACK && too_far;
  endsequence

  a_loss_sets: assert property (@(posedge i_clk) disable iff (i_rst)
    s_loss |=> loss_of_lock_flag)
    else $error("loss flag not set on large error");
  a_fll_on: assert property (@(posedge i_clk) disable iff (i_rst)
    s_loss |=> ##1 o_frequency_acquisition_loop && !o_phase_loop_en)
    else $error("acquisition loop not started");
  a_clear_close: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(loss_of_lock_flag) |-> $past(close_in && meas.valid))
    else $error("flag cleared outside window");
  a_handover: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(loss_of_lock_flag) |=> o_phase_loop_en)
    else $error("no handover to phase loops");
  a_flag_holds: assert property (@(posedge i_clk) disable iff (i_rst)
    !meas.valid |=> $stable(loss_of_lock_flag))
    else $error("flag moved without measurement");
  a_sticky_set: assert property (@(posedge i_clk) disable iff (i_rst)
    loss_evt |=> sticky_lock_loss)
    else $error("sticky bit not set");
  a_pin_mirror: assert property (@(posedge i_clk) disable iff (i_rst)
    lock_control_reg[LCK_PIN_MODE] |=>
      o_loss_of_lock_pin == $past(sticky_lock_loss))
    else $error("pin does not mirror sticky bit");
  a_ref_select: assert property (@(posedge i_clk) disable iff (i_rst)
    gate_end && mode == MODE_REF |=> meas.tgt_cnt == $past(ref_cnt))
    else $error("reference count not used");
  a_sticky_clr: assert property (@(posedge i_clk) disable iff (i_rst)
    sticky_lock_loss && !loss_evt && !lock_control_reg[LCK_STICKY_CLR]
      && sticky_clr_prev |=> !sticky_lock_loss)
    else $error("sticky bit not cleared");

endmodule : cdr_lock_detector

// ===== bench/far_side_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Far side: divided oscillator, divided data and reference clock
// ---------------------------------------------------------------
module far_side_model (
  input  wire logic [15:0] i_data_half,  // Half period, 10 ps steps
  input  wire logic [15:0] i_ref_half,   // Half period, 10 ps steps
  output logic             o_vco_div,
  output logic             o_data_edge,
  output logic             o_ref_clk
);
  // Oscillator fixed at six clock periods so gate counts come out exact
  initial begin
    o_vco_div = 1'b0;
    #1;
    forever #24 o_vco_div = ~o_vco_div;
  end

  // Divided serial stream; its rate sets the data-mode target
  initial begin
    o_data_edge = 1'b0;
    #3;
    forever #(i_data_half / 100.0) o_data_edge = ~o_data_edge;
  end

  // Reference runs free, already scaled by range and divider
  initial begin
    o_ref_clk = 1'b0;
    #5;
    forever #(i_ref_half / 100.0) o_ref_clk = ~o_ref_clk;
  end
endmodule : far_side_model

// ===== bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import lock_det_pkg::*;

  // Short gate keeps the run short; 2000 edges per gate, 500 ppm a count
  localparam int GATE = 12000;

  typedef struct {
    logic [7:0] wd;
    logic [6:0] exp;
  } row_t;

  logic        i_clk;
  logic        i_rst;
  logic        i_wr;
  logic        i_rd;
  logic [3:0]  i_addr;
  logic [7:0]  i_wdata;
  logic [7:0]  o_rdata;
  logic [7:0]  rd;
  logic        vco;
  logic        dat;
  logic        refc;
  logic        pin;
  logic        acq;
  logic        ph;
  logic        sel;
  logic        irq;
  logic [1:0]  rng;
  logic [3:0]  dv;
  logic [15:0] data_half;
  logic [15:0] ref_half;
  int          num_errors;
  int          cmp_count;
  row_t        rows [4] = '{'{8'hC1, 7'h70}, '{8'h3C, 7'h0F},
                            '{8'h8A, 7'h22}, '{8'h00, 7'h00}};

  far_side_model far_side_model_inst (
    .i_data_half (data_half),
    .i_ref_half  (ref_half),
    .o_vco_div   (vco),
    .o_data_edge (dat),
    .o_ref_clk   (refc)
  );

  cdr_lock_detector #(.GATE_CYC(GATE)) cdr_lock_detector_inst (
    .i_clk                        (i_clk),
    .i_rst                        (i_rst),
    .i_vco_div                    (vco),
    .i_data_edge                  (dat),
    .i_aid_reference_clock        (refc),
    .i_addr                       (i_addr),
    .i_wdata                      (i_wdata),
    .i_wr                         (i_wr),
    .i_rd                         (i_rd),
    .o_rdata                      (o_rdata),
    .o_loss_of_lock_pin           (pin),
    .o_frequency_acquisition_loop (acq),
    .o_phase_loop_en              (ph),
    .o_ref_sel                    (sel),
    .o_ref_range                  (rng),
    .o_ref_div                    (dv),
    .o_irq                        (irq)
  );

  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    if (num_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd_reg

  // Bounded wait for the loop handover; no handover within three gates counts as a fault
  task automatic wait_ph(input logic v);
    int n;
    n = 0;
    while (ph !== v && n < 3 * GATE) begin
      @(posedge i_clk);
      n++;
    end
    if (ph !== v) begin
      $display("Error loop handover expected %b seen %b", v, ph);
      num_errors++;
      complete_run();
    end
    repeat (3) @(posedge i_clk);
    #1;
  endtask : wait_ph

  task automatic settle();
    repeat (3) @(posedge i_clk);
    #1;
  endtask : settle

  // Free-running clock
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    i_rst      = 1'b1;
    i_wr       = 1'b0;
    i_rd       = 1'b0;
    i_addr     = 4'h0;
    i_wdata    = 8'h00;
    data_half  = 16'h0960;
    ref_half   = 16'h0960;
    num_errors = 0;
    cmp_count  = 0;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    chk("reset outputs", 8'h06, {5'h00, pin, acq, ph});
    chk("reset irq", 8'h00, {7'h00, irq});
    foreach (rows[i]) begin
      wr(ADDR_ACQ_CTRL, rows[i].wd);
      settle();
      chk("ref fields", {1'b0, rows[i].exp}, {1'b0, sel, rng, dv});
      rd_reg(ADDR_ACQ_CTRL, rd);
      chk("acq readback", rows[i].wd, rd);
    end
    rd_reg(4'h0, rd);
    chk("unmapped read", 8'h00, rd);
    // Equal rates in data mode must lock and hand over
    wait_ph(1'b1);
    chk("lock outputs", 8'h01, {5'h00, pin, acq, ph});
    rd_reg(ADDR_IRQ_STAT, rd);
    chk("irq lock event", 8'h02, rd);
    wr(ADDR_LOCK_CTRL, 8'h40);
    wr(ADDR_LOCK_CTRL, 8'h00);
    rd_reg(ADDR_STATUS, rd);
    chk("status cleared", 8'h00, rd);
    wr(ADDR_IRQ_CLR, 8'h03);
    wr(ADDR_IRQ_EN, 8'h01);
    // Reference mode: data far off, reference inside the band
    data_half <= 16'h099C;
    ref_half  <= 16'h095E;
    wr(ADDR_ACQ_CTRL, 8'h8D);
    repeat (2 * GATE + 8) @(posedge i_clk);
    #1;
    chk("ref hold", 8'h01, {5'h00, pin, acq, ph});
    chk("irq idle", 8'h00, {7'h00, irq});
    // Reference drifts beyond the upper threshold
    ref_half <= 16'h099C;
    wait_ph(1'b0);
    #1;
    chk("loss outputs", 8'h06, {5'h00, pin, acq, ph});
    rd_reg(ADDR_STATUS, rd);
    chk("status loss", 8'h18, rd);
    chk("irq raised", 8'h01, {7'h00, irq});
    wr(ADDR_IRQ_EN, 8'h00);
    settle();
    chk("irq masked", 8'h00, {7'h00, irq});
    wr(ADDR_IRQ_EN, 8'h01);
    settle();
    chk("irq unmasked", 8'h01, {7'h00, irq});
    wr(ADDR_IRQ_CLR, 8'h01);
    settle();
    chk("irq cleared", 8'h00, {7'h00, irq});
    rd_reg(ADDR_IRQ_STAT, rd);
    chk("irq status", 8'h00, rd);
    // Reference back in band: relock, sticky bit survives
    ref_half <= 16'h0960;
    wait_ph(1'b1);
    #1;
    chk("relock outputs", 8'h01, {5'h00, pin, acq, ph});
    rd_reg(ADDR_STATUS, rd);
    chk("status sticky", 8'h10, rd);
    wr(ADDR_LOCK_CTRL, 8'h80);
    settle();
    chk("pin sticky", 8'h01, {7'h00, pin});
    wr(ADDR_LOCK_CTRL, 8'hC0);
    wr(ADDR_LOCK_CTRL, 8'h80);
    settle();
    chk("pin cleared", 8'h00, {7'h00, pin});
    rd_reg(ADDR_STATUS, rd);
    chk("status clear", 8'h00, rd);
    // Back to data mode with the data still far off: loss again
    wr(ADDR_ACQ_CTRL, 8'h00);
    wait_ph(1'b0);
    chk("data loss", 8'h06, {5'h00, pin, acq, ph});
    chk("irq reloss", 8'h01, {7'h00, irq});
    rd_reg(ADDR_STATUS, rd);
    chk("status reloss", 8'h18, rd);
    complete_run();
  end
endmodule : tb_top
